// ==== include/cfgov_pkg.sv ====
// Purpose: constants for the configuration overlay command handler
// Assumes: 32-bit Avalon-MM register access, word addresses as byte offsets
// Notes: offsets, fields, command and reason codes live here; status values and counts stay literal
package cfgov_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;      // W: [7:0] cmd, [15:8] features, [16] dev select
  localparam logic [7:0] REG_TASK = 8'h04;     // R: [7:0] sec cnt, [15:8] sec num, [23:16] cyl lo, [31:24] cyl hi
  localparam logic [7:0] REG_STAT = 8'h08;     // R: [7:0] status, [15:8] error
  localparam logic [7:0] REG_DATA = 8'h0c;     // RW: 16-bit PIO data word
  localparam logic [7:0] REG_CTRL = 8'h10;     // RW: [0] hpa, [1] sec locked, [2] sec enabled, [3] setmax lock, [4] dev id
  localparam logic [7:0] REG_EFF0 = 8'h14;     // R: [15:0] word 1 eff, [31:16] word 2 eff
  localparam logic [7:0] REG_EFF1 = 8'h18;     // R: [15:0] word 7 eff, [16] modified, [17] frozen
  localparam logic [7:0] REG_MAXL = 8'h1c;     // R: low 32 bits of effective max LBA
  localparam logic [7:0] REG_MAXH = 8'h20;     // R: high 16 bits of effective max LBA
  // Command and subcommands
  localparam logic [7:0] CMD_OVL = 8'hb1;
  localparam logic [7:0] SUB_RESTORE = 8'hc0;
  localparam logic [7:0] SUB_FREEZE = 8'hc1;
  localparam logic [7:0] SUB_IDENT = 8'hc2;
  localparam logic [7:0] SUB_SET = 8'hc3;
  // Structure fields
  localparam logic [15:0] OVL_REV = 16'h0001;
  localparam logic [7:0] OVL_SIG = 8'ha5;
  localparam logic [7:0] OVL_LAST = 8'hff;     // Index of word 255
  localparam logic [15:0] CAP_W1 = 16'h0007;   // Multiword DMA 2..0
  localparam logic [15:0] CAP_W2 = 16'h003f;   // Ultra DMA 5..0
  localparam logic [15:0] CAP_W7 = 16'h01ff;   // Feature bits 8..0
  localparam logic [47:0] CAP_MAXLBA = 48'h0000_0eff_ffff;
  localparam int SEC_BIT = 3;                  // Security support in word 7
  // Abort reason codes
  localparam logic [7:0] RSN_FROZEN = 8'h01;
  localparam logic [7:0] RSN_SECLOCK = 8'h02;
  localparam logic [7:0] RSN_MODIFIED = 8'h03;
  localparam logic [7:0] RSN_DISABLE = 8'h04;
  localparam logic [7:0] RSN_SETMAX = 8'h05;
  localparam logic [7:0] RSN_HPA = 8'h06;
  localparam logic [7:0] RSN_UNSUP = 8'h07;
  localparam logic [7:0] RSN_BADSUB = 8'h08;
  localparam logic [7:0] RSN_OTHER = 8'hff;
  // Status and error bits
  localparam int ST_ERR = 0;
  localparam int ST_DRQ = 3;
  localparam int ST_DSC = 4;
  localparam int ST_RDY = 6;
  localparam int ST_BSY = 7;
  localparam int ER_ABT = 2;
  localparam logic [7:0] WORD_MAXLBA = 8'h03;
  localparam logic [7:0] WORD_FEAT = 8'h07;
  typedef enum logic [2:0] {CFGOV_IDLE, CFGOV_EXEC, CFGOV_DIN, CFGOV_DOUT, CFGOV_CHECK} cfgov_state_t;
endpackage

// ==== tb/cfgov_chk_sva.sv ====
// Purpose: bus timing and status relations of the overlay handler
// Assumes: registered read data, answer one cycle after a request is taken
// Notes: sees only the handler ports
`timescale 1ns/1ps
module cfgov_chk
  import cfgov_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic pwr_down_n, // Power-down
  input wire logic [7:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic avs_response_err // Unmapped flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  logic req; // Any request
  logic ans; // Answer edge
  logic rd_st; // Status answer
  assign req = avs_read | avs_write;
  assign ans = req & ~avs_waitrequest;
  assign rd_st = avs_read & ~avs_waitrequest & (avs_address == REG_STAT);
  ////////////////////////////////////////////////////////////////
  property p_answer; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_first; req && $past(ans) |-> avs_waitrequest; endproperty
  property p_abt; rd_st |-> avs_readdata[ST_ERR] == avs_readdata[8 + ER_ABT]; endproperty
  property p_nodrq; rd_st && avs_readdata[ST_ERR] |-> !avs_readdata[ST_DRQ]; endproperty
  property p_unmap; avs_read && !avs_waitrequest && avs_address > REG_MAXH |-> avs_response_err; endproperty
  property p_mapped; rd_st |-> !avs_response_err; endproperty
  property p_caps;
    avs_read && !avs_waitrequest && avs_address == REG_EFF0 |-> (avs_readdata & ~{CAP_W2, CAP_W1}) == 32'h0;
  endproperty
  property p_w7;
    avs_read && !avs_waitrequest && avs_address == REG_EFF1 |-> (avs_readdata[15:0] & ~CAP_W7) == 16'h0;
  endproperty
  property p_hold; !req && $past(!req) |-> $stable(avs_readdata); endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  a_first: assert property (p_first) else $error("request answered in its first cycle");
  a_abt: assert property (p_abt) else $error("error bit and abort bit disagree");
  a_nodrq: assert property (p_nodrq) else $error("data request with error");
  a_unmap: assert property (p_unmap) else $error("unmapped read not flagged");
  a_mapped: assert property (p_mapped) else $error("status read flagged");
  a_caps: assert property (p_caps) else $error("unsupported mode bit reported");
  a_w7: assert property (p_w7) else $error("unsupported feature bit reported");
  a_hold: assert property (p_hold) else $error("read data moved while idle");
  c_abort: cover property (rd_st && avs_readdata[ST_ERR]);
  c_drq: cover property (rd_st && avs_readdata[ST_DRQ]);
  c_unmap: cover property (ans && avs_response_err);
endmodule
bind cfgov_handler cfgov_chk cfgov_chk_i (.clk_sys(clk_sys), .rst(rst), .pwr_down_n(pwr_down_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err));

// ==== tb/cfgov_handler_bench.sv ====
// Purpose: self-checking bench for the overlay handler
// Assumes: host model performs every bus access
// Notes: power-down initialises freeze and overlay state
`timescale 1ns/1ps
module cfgov_handler_bench
  import cfgov_pkg::*;
;
  logic clk_sys = 1'b0; // Clock
  logic rst = 1'b1; // Reset
  logic pwr_down_n = 1'b0; // Power-down
  logic [7:0] avs_address; // Bus
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic avs_response_err;
  logic [31:0] q; // Last read data
  int failures = 0;
  int tests_run = 0;
  cfgov_handler cfgov_handler_i (.clk_sys(clk_sys), .rst(rst), .pwr_down_n(pwr_down_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err));
  cfgov_host cfgov_host_i (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err));
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    failures += cfgov_host_i.timeouts;
    $display("checks=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    cfgov_host_i.access(1'b0, a, 32'h0, q);
  endtask
  // Poll until not busy, then compare error and status bytes
  task automatic poll(input logic [15:0] exp);
    int n = 0;
    rd(REG_STAT);
    while (q[ST_BSY] !== 1'b0 && n < 20)
    begin
      rd(REG_STAT);
      n++;
    end
    // A busy that never ends is a mismatch and closes the run
    if (n >= 20)
    begin
      failures++;
      end_of_test();
    end
    else
      chk({16'h0, q[15:0]}, {16'h0, exp});
  endtask
  task automatic abort_chk(input logic [31:0] mask, input logic [31:0] exp);
    poll(16'h0451);
    rd(REG_TASK);
    chk(q & mask, exp);
  endtask
  task automatic try_set(input logic [15:0] w1, w2, w7, input logic [47:0] mx, input logic bad);
    cfgov_host_i.issue(SUB_SET, 1'b0);
    poll(16'h0058);
    cfgov_host_i.send_overlay(w1, w2, w7, mx, bad);
  endtask
  // Full identify transfer against the complete capability set
  task automatic ident;
    logic [15:0] exp [8];
    logic [7:0] sum = 8'h00;
    exp = '{OVL_REV, CAP_W1, CAP_W2, CAP_MAXLBA[15:0], CAP_MAXLBA[31:16], CAP_MAXLBA[47:32], 16'h0, CAP_W7};
    cfgov_host_i.issue(SUB_IDENT, 1'b0);
    poll(16'h0058);
    for (int i = 0; i < 256; i++)
    begin
      rd(REG_DATA);
      sum += q[7:0] + q[15:8];
      if (i < 8)
        chk({16'h0, q[15:0]}, {16'h0, exp[i]});
    end
    chk({24'h0, q[7:0]}, {24'h0, OVL_SIG});
    chk({24'h0, sum}, 32'h0);
    poll(16'h0050);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset leaves freeze and overlay alone; power-down after release clears them
    repeat (2) @(posedge clk_sys);
    pwr_down_n <= 1'b1;
    poll(16'h0050);
    cfgov_host_i.access(1'b1, REG_CTRL, 32'h0, q);
    rd(8'h40);
    chk({31'h0, cfgov_host_i.err_seen}, 32'h1);
    ident();
    try_set(16'h000b, 16'h000f, 16'h01df, CAP_MAXLBA, 1'b0);
    poll(16'h0050);
    rd(REG_EFF0);
    chk(q, 32'h000f_0003);
    rd(REG_EFF1);
    chk(q, 32'h0001_01df);
    ident();
    cfgov_host_i.issue(SUB_SET, 1'b0);
    abort_chk(32'h0000_00ff, {24'h0, RSN_MODIFIED});
    cfgov_host_i.issue(SUB_RESTORE, 1'b0);
    poll(16'h0050);
    rd(REG_EFF0);
    chk(q, {CAP_W2, CAP_W1});
    cfgov_host_i.access(1'b1, REG_CTRL, 32'h2, q);
    cfgov_host_i.issue(SUB_SET, 1'b0);
    abort_chk(32'h0000_00ff, {24'h0, RSN_SECLOCK});
    cfgov_host_i.access(1'b1, REG_CTRL, 32'h8, q);
    cfgov_host_i.issue(SUB_SET, 1'b0);
    abort_chk(32'h0000_00ff, {24'h0, RSN_SETMAX});
    cfgov_host_i.access(1'b1, REG_CTRL, 32'h0, q);
    try_set(CAP_W1, CAP_W2, CAP_W7, CAP_MAXLBA, 1'b1);
    abort_chk(32'h0000_00ff, {24'h0, RSN_OTHER});
    cfgov_host_i.access(1'b1, REG_CTRL, 32'h4, q);
    try_set(CAP_W1, CAP_W2, 16'h01f7, CAP_MAXLBA, 1'b0);
    abort_chk(32'hffff_ffff, 32'h0708_0004);
    cfgov_host_i.access(1'b1, REG_CTRL, 32'h1, q);
    try_set(CAP_W1, CAP_W2, CAP_W7, CAP_MAXLBA - 48'h1, 1'b0);
    abort_chk(32'hff00_00ff, {WORD_MAXLBA, 16'h0, RSN_HPA});
    cfgov_host_i.access(1'b1, REG_CTRL, 32'h0, q);
    cfgov_host_i.issue(8'hc4, 1'b0);
    abort_chk(32'h0000_00ff, {24'h0, RSN_BADSUB});
    cfgov_host_i.issue(SUB_FREEZE, 1'b1);
    rd(REG_EFF1);
    chk(q[17], 1'b0);
    cfgov_host_i.issue(SUB_FREEZE, 1'b0);
    poll(16'h0050);
    for (int s = 0; s < 4; s++)
    begin
      cfgov_host_i.issue(SUB_RESTORE + 8'(s), 1'b0);
      abort_chk(32'h0000_00ff, {24'h0, RSN_FROZEN});
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    cfgov_host_i.issue(SUB_IDENT, 1'b0);
    abort_chk(32'h0000_00ff, {24'h0, RSN_FROZEN});
    pwr_down_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    pwr_down_n <= 1'b1;
    ident();
    end_of_test();
  end
  // Cuts a hang short
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule

// ==== tb/cfgov_host.sv ====
// Purpose: host adapter model driving task-file accesses
// Assumes: answer awaited at a rising edge with waitrequest low
// Notes: one access task serves read and write
`timescale 1ns/1ps
module cfgov_host
  import cfgov_pkg::*;
(
  input wire logic clk_sys, // Clock
  output logic [7:0] avs_address = 8'h00, // Address
  output logic avs_read = 1'b0, // Read
  output logic avs_write = 1'b0, // Write
  output logic [31:0] avs_writedata = 32'h0, // Write data
  output logic [3:0] avs_byteenable = 4'hf, // All lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic avs_response_err // Unmapped flag
);
  int timeouts = 0; // Waits that ran out
  logic err_seen = 1'b0; // Flag of last answer
  ////////////////////////////////////////////////////////////////
  // Request raised after an edge, held until a rising edge samples waitrequest low
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
    end
    // Answer taken at the edge that sees waitrequest low, then released
    q = avs_readdata;
    err_seen = avs_response_err;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40)
    begin
      timeouts++;
      cfgov_handler_bench.end_of_test();
    end
  endtask
  // Command word with subcommand and device number
  task automatic issue(input logic [7:0] sub, input logic dev);
    logic [31:0] q;
    access(1'b1, REG_CMD, {15'h0, dev, sub, CMD_OVL}, q);
  endtask
  // Whole overlay, signature and checksum; bad spoils the checksum
  task automatic send_overlay(input logic [15:0] w1, w2, w7, input logic [47:0] mx, input logic bad);
    logic [15:0] ov [256];
    logic [7:0] sum;
    logic [31:0] q;
    foreach (ov[i])
      ov[i] = 16'h0000;
    ov[0] = OVL_REV;
    ov[1] = w1;
    ov[2] = w2;
    ov[3] = mx[15:0];
    ov[4] = mx[31:16];
    ov[5] = mx[47:32];
    ov[7] = w7;
    ov[255] = {8'h00, OVL_SIG};
    sum = 8'h00;
    foreach (ov[i])
      sum += ov[i][7:0] + ov[i][15:8];
    ov[255][15:8] = 8'h00 - sum - {7'h0, bad};
    foreach (ov[i])
      access(1'b1, REG_DATA, {16'h0000, ov[i]}, q);
  endtask
endmodule

// ==== verilog/cfgov_handler.sv ====
// Purpose: configuration overlay command handler behind an Avalon-MM slave
// Assumes: one clock at 10 MHz, host writes task file through the bus
// Notes: frozen flag and overlay survive rst only when pwr_down_n stays high
// Operation
// [RL1] Features C0..C3 select restore, freeze, identify, set
// [RL2] Restore cancels all reductions from set
// [RL3] After freeze, abort every overlay subcommand
// [RL4] Frozen held until power-down, survives resets
// [RL5] Identify returns 512-byte structure via PIO in
// [RL6] Identify-device shows reduced set, overlay shows full
// [RL7] Set may clear bits in capability words
// [RL8] Overlay bits not supported are ignored
// [RL9] Abort reports reason, word, bit low byte
// [RL10] Bit position high byte goes to sector number
// [RL11] Reasons 01h to 04h as listed
// [RL12] Reasons 05h to 08h and FFh as listed
// [RL13] Max LBA change with HPA: word 3, reason 06h
// [RL14] Security disable while enabled: word 7, bit 3, 04h
// [RL15] Words 0-2: revision, multiword and Ultra DMA modes
// [RL16] Words 3-7: max LBA and feature bits
// [RL17] Last word holds signature and checksum
// [RL18] All 512 bytes sum to zero
// [RL19] Device select bit picks master or slave
// [RL20] Abort sets ABT and ERR, no data request
// [RL21] Set with bad sum or signature aborts
`timescale 1ns/1ps
module cfgov_handler
  import cfgov_pkg::*;
(
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rst, // Async reset, active high
  input wire logic pwr_down_n, // Power-down clear, active low
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic avs_response_err // High on unmapped access
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    cfgov_state_t st;      // Command sequencer
    logic frozen;          // Freeze lock latch
    logic modified;        // Set already applied
    logic [15:0] w1;       // Effective multiword modes
    logic [15:0] w2;       // Effective Ultra modes
    logic [15:0] w7;       // Effective features
    logic [47:0] maxlba;   // Effective max LBA
    logic [15:0] rx1;      // Received overlay words
    logic [15:0] rx2;
    logic [15:0] rx7;
    logic [47:0] rxlba;
    logic [15:0] rxlast;   // Received word 255
    logic [7:0] sum;       // Running byte sum
    logic [7:0] idx;       // Word index in transfer
    logic [7:0] feat;      // Latched features
    logic [7:0] sec_cnt;   // Task file outputs
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] status;
    logic [7:0] error;
    logic [4:0] ctrl;      // Environment bits from software
    logic [15:0] dout;     // PIO data out word
    logic [31:0] rdata;    // Registered read data
    logic rerr;            // Registered bus error
    logic ack;             // Bus answer pulse
  } cfgov_reg_t;

  cfgov_reg_t r_ff;   // Current state
  cfgov_reg_t nxt_r;  // Next state

  logic [15:0] ident_word; // Identify word at current index
  logic [7:0] ident_sum;   // Checksum over words 0..254 and signature
  logic hit; // Request addressed to this drive
  logic access; // Bus request pending
  logic [15:0] wdata; // Data word being written

  ////////////////////////////////////////////////////////////////////////////
  // Full capability checksum, constant over structure; see [RL18]
  always_comb
  begin
    ident_sum = OVL_REV[7:0] + OVL_REV[15:8] + CAP_W1[7:0] + CAP_W1[15:8] + CAP_W2[7:0] + CAP_W2[15:8]
      + CAP_MAXLBA[7:0] + CAP_MAXLBA[15:8] + CAP_MAXLBA[23:16] + CAP_MAXLBA[31:24]
      + CAP_MAXLBA[39:32] + CAP_MAXLBA[47:40] + CAP_W7[7:0] + CAP_W7[15:8] + OVL_SIG;
    ident_sum = 8'(~ident_sum + 8'h01);
  end

  // Full structure word by index; see [RL5] [RL15] [RL16] [RL17]
  always_comb
  begin
    if (r_ff.idx == 8'h00)
      ident_word = OVL_REV;
    else if (r_ff.idx == 8'h01)
      ident_word = CAP_W1;
    else if (r_ff.idx == 8'h02)
      ident_word = CAP_W2;
    else if (r_ff.idx == 8'h03)
      ident_word = CAP_MAXLBA[15:0];
    else if (r_ff.idx == 8'h04)
      ident_word = CAP_MAXLBA[31:16];
    else if (r_ff.idx == 8'h05)
      ident_word = CAP_MAXLBA[47:32];
    else if (r_ff.idx == 8'h06)
      ident_word = 16'h0000;
    else if (r_ff.idx == 8'h07)
      ident_word = CAP_W7;
    else if (r_ff.idx == OVL_LAST)
      ident_word = {ident_sum, OVL_SIG};
    else
      ident_word = 16'h0000; // Reserved words read zero
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.ack = 1'b0;
    nxt_r.rerr = 1'b0;
    access = (avs_read | avs_write) & ~r_ff.ack;
    wdata = avs_writedata[15:0];
    hit = (avs_writedata[16] == r_ff.ctrl[4]); // Drive address match; see [RL19]
    if (access)
    begin
      nxt_r.ack = 1'b1;
      nxt_r.rdata = 32'h0000_0000;
      if (avs_address == REG_CMD)
      begin
        if (avs_write && avs_byteenable[0] && r_ff.st == CFGOV_IDLE && hit && avs_writedata[7:0] == CMD_OVL)
        begin
          nxt_r.feat = avs_writedata[15:8];
          nxt_r.st = CFGOV_EXEC;
          nxt_r.status = 8'h80; // Busy while decoding
          nxt_r.error = 8'h00;
        end
      end
      else if (avs_address == REG_TASK)
        nxt_r.rdata = {r_ff.cyl_hi, r_ff.cyl_lo, r_ff.sec_num, r_ff.sec_cnt};
      else if (avs_address == REG_STAT)
        nxt_r.rdata = {16'h0000, r_ff.error, r_ff.status};
      else if (avs_address == REG_DATA)
      begin
        nxt_r.rdata = {16'h0000, r_ff.dout};
        if (avs_read && r_ff.st == CFGOV_DIN)
        begin
          // Word taken by host; advance
          nxt_r.idx = 8'(r_ff.idx + 8'h01);
          if (r_ff.idx == OVL_LAST)
          begin
            nxt_r.st = CFGOV_IDLE;
            nxt_r.status = 8'h50;
          end
        end
        else if (avs_write && r_ff.st == CFGOV_DOUT)
        begin
          // Capture overlay word and fold bytes into sum; see [RL18]
          nxt_r.sum = 8'(r_ff.sum + wdata[7:0] + wdata[15:8]);
          nxt_r.idx = 8'(r_ff.idx + 8'h01);
          if (r_ff.idx == 8'h01)
            nxt_r.rx1 = wdata;
          else if (r_ff.idx == 8'h02)
            nxt_r.rx2 = wdata;
          else if (r_ff.idx == 8'h03)
            nxt_r.rxlba[15:0] = wdata;
          else if (r_ff.idx == 8'h04)
            nxt_r.rxlba[31:16] = wdata;
          else if (r_ff.idx == 8'h05)
            nxt_r.rxlba[47:32] = wdata;
          else if (r_ff.idx == 8'h07)
            nxt_r.rx7 = wdata;
          else if (r_ff.idx == OVL_LAST)
          begin
            nxt_r.rxlast = wdata;
            nxt_r.st = CFGOV_CHECK;
            nxt_r.status = 8'h80;
          end
        end
      end
      else if (avs_address == REG_CTRL)
      begin
        nxt_r.rdata = {27'h0, r_ff.ctrl};
        if (avs_write && avs_byteenable[0])
          nxt_r.ctrl = avs_writedata[4:0];
      end
      else if (avs_address == REG_EFF0)
        nxt_r.rdata = {r_ff.w2, r_ff.w1}; // Reduced set for identify-device; see [RL6]
      else if (avs_address == REG_EFF1)
        nxt_r.rdata = {14'h0, r_ff.frozen, r_ff.modified, r_ff.w7};
      else if (avs_address == REG_MAXL)
        nxt_r.rdata = r_ff.maxlba[31:0];
      else if (avs_address == REG_MAXH)
        nxt_r.rdata = {16'h0000, r_ff.maxlba[47:32]};
      else
        nxt_r.rerr = 1'b1; // Unmapped address answers with error
    end

    // Command sequencer
    case (r_ff.st)
      CFGOV_EXEC:
      begin
        nxt_r.st = CFGOV_IDLE;
        nxt_r.status = 8'h50; // Ready, seek complete
        nxt_r.idx = 8'h00;
        nxt_r.sum = 8'h00;
        nxt_r.sec_cnt = 8'h00;
        nxt_r.sec_num = 8'h00;
        nxt_r.cyl_lo = 8'h00;
        nxt_r.cyl_hi = 8'h00;
        if (r_ff.frozen)
          nxt_r.sec_cnt = RSN_FROZEN; // see [RL3] [RL11]
        else if (r_ff.feat == SUB_RESTORE)
        begin
          if (r_ff.ctrl[1])
            nxt_r.sec_cnt = RSN_SECLOCK;
          else if (r_ff.ctrl[0] && r_ff.maxlba != CAP_MAXLBA)
          begin
            nxt_r.sec_cnt = RSN_HPA; // see [RL13]
            nxt_r.cyl_hi = WORD_MAXLBA;
          end
          else
          begin
            // Restore the full selectable set; see [RL2]
            nxt_r.w1 = CAP_W1;
            nxt_r.w2 = CAP_W2;
            nxt_r.w7 = CAP_W7;
            nxt_r.maxlba = CAP_MAXLBA;
            nxt_r.modified = 1'b0;
          end
        end
        else if (r_ff.feat == SUB_FREEZE)
          nxt_r.frozen = 1'b1; // see [RL3]
        else if (r_ff.feat == SUB_IDENT)
          nxt_r.st = CFGOV_DIN; // see [RL5]
        else if (r_ff.feat == SUB_SET)
        begin
          if (r_ff.ctrl[1])
            nxt_r.sec_cnt = RSN_SECLOCK;
          else if (r_ff.modified)
            nxt_r.sec_cnt = RSN_MODIFIED;
          else if (r_ff.ctrl[3])
            nxt_r.sec_cnt = RSN_SETMAX;
          else
            nxt_r.st = CFGOV_DOUT;
        end
        else
          nxt_r.sec_cnt = RSN_BADSUB; // see [RL1] [RL12]
        if (nxt_r.sec_cnt != 8'h00)
        begin
          // Abort without data request; see [RL20]
          nxt_r.st = CFGOV_IDLE;
          nxt_r.status = 8'h51;
          nxt_r.error = 8'h04;
        end
        else if (nxt_r.st == CFGOV_DIN || nxt_r.st == CFGOV_DOUT)
          nxt_r.status = 8'h58; // Data request
      end
      CFGOV_DIN:
        nxt_r.dout = ident_word;
      CFGOV_CHECK:
      begin
        nxt_r.st = CFGOV_IDLE;
        nxt_r.status = 8'h50;
        if (r_ff.sum != 8'h00 || r_ff.rxlast[7:0] != OVL_SIG)
          nxt_r.sec_cnt = RSN_OTHER; // see [RL21]
        else if (r_ff.ctrl[0] && (r_ff.rxlba & CAP_MAXLBA) != r_ff.maxlba)
        begin
          nxt_r.sec_cnt = RSN_HPA; // see [RL13]
          nxt_r.cyl_hi = WORD_MAXLBA;
        end
        else if (r_ff.ctrl[2] && !r_ff.rx7[SEC_BIT] && r_ff.w7[SEC_BIT])
        begin
          nxt_r.sec_cnt = RSN_DISABLE; // see [RL14]
          nxt_r.cyl_hi = WORD_FEAT;
          nxt_r.cyl_lo = 8'(1 << SEC_BIT); // see [RL9]
          nxt_r.sec_num = 8'h00; // see [RL10]
        end
        else
        begin
          // Mask unsupported bits so they leave capability unchanged; see [RL7] [RL8]
          nxt_r.w1 = r_ff.rx1 & CAP_W1;
          nxt_r.w2 = r_ff.rx2 & CAP_W2;
          nxt_r.w7 = r_ff.rx7 & CAP_W7;
          nxt_r.maxlba = r_ff.rxlba & CAP_MAXLBA;
          nxt_r.modified = 1'b1;
        end
        if (nxt_r.sec_cnt != 8'h00)
        begin
          nxt_r.status = 8'h51; // see [RL20]
          nxt_r.error = 8'h04;
        end
      end
      default:
      begin
      end
    endcase

    // Power-down alone clears freeze and, like restore, clears overlay; see [RL4]
    if (!pwr_down_n)
    begin
      nxt_r.frozen = 1'b0;
      nxt_r.modified = 1'b0;
      nxt_r.w1 = CAP_W1;
      nxt_r.w2 = CAP_W2;
      nxt_r.w7 = CAP_W7;
      nxt_r.maxlba = CAP_MAXLBA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves overlay and freeze untouched; see [RL4]
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      r_ff.st <= CFGOV_IDLE;
      r_ff.status <= 8'h50;
      r_ff.error <= 8'h00;
      r_ff.ack <= 1'b0;
      r_ff.rerr <= 1'b0;
      r_ff.rdata <= 32'h0000_0000;
      r_ff.idx <= 8'h00;
      r_ff.sum <= 8'h00;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // Bus answers one cycle after request
  assign avs_waitrequest = (avs_read | avs_write) & ~r_ff.ack;
  assign avs_readdata = r_ff.rdata;
  assign avs_response_err = r_ff.rerr;

endmodule
